// File: sac_pkg.sv
package sac_pkg;
	// Register indices on the byte-wide register port.
	localparam logic [2:0] OFF_SEL  = 3'h0;
	localparam logic [2:0] OFF_CSA  = 3'h1;
	localparam logic [2:0] OFF_CSB  = 3'h2;
	localparam logic [2:0] OFF_RESL = 3'h3;
	localparam logic [2:0] OFF_RESH = 3'h4;
	localparam logic [2:0] OFF_TFLG = 3'h5;
	// Field positions.
	localparam int CSA_EN    = 7;
	localparam int CSA_START = 6;
	localparam int CSA_ATE   = 5;
	localparam int CSA_DONE  = 4;
	localparam int SEL_REF   = 6;
	localparam int CSB_LADJ  = 3;
	// Values after reset.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_RES  = 10'h000;
	localparam logic [7:0] RST_PCNT = 8'h00;
	localparam logic [5:0] RST_HC   = 6'h00;
	// Conversion timing in converter clock cycles.
	localparam int CONV_NORM_CYC  = 13;
	localparam int CONV_FIRST_CYC = 25;
	// Timing counted in converter half cycles from the start edge.
	localparam logic [5:0] HC_NORM_END   = 6'(2 * CONV_NORM_CYC);
	localparam logic [5:0] HC_FIRST_END  = 6'(2 * CONV_FIRST_CYC);
	localparam logic [5:0] HC_AUTO_END   = 6'h1B;
	localparam logic [5:0] HC_NORM_SAMP  = 6'h03;
	localparam logic [5:0] HC_FIRST_SAMP = 6'h1B;
	localparam logic [5:0] HC_AUTO_SAMP  = 6'h04;
	// System clocks of trigger synchronisation.
	localparam int TRIG_SYNC = 3;
	// Conversion sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10
	} sac_state_type;
	// Signals towards the analog multiplexer and converter core.
	typedef struct packed {
		logic       sample;
		logic       busy;
		logic       ref_sel;
		logic [3:0] channel;
	} sac_core_type;
endpackage

// File: sac_conv_ctrl.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Selections take effect only while enabled.
// - Result split high/low, right or left adjusted.
// - Low read blocks updates until high read.
// - Done flag set even when result dropped.
// - Start bit begins conversion, clears when done unless free running.
// - Channel change waits for current conversion.
// - Trigger edge resets prescaler, starts conversion.
// - Edges during conversion ignored, no level retrigger.
// - Trigger flags set always, clear to retrigger.
// - Done flag trigger runs conversions back to back.
// - Start bit reads one during any conversion.
// - Prescaler runs only while enabled.
// - Software start begins on next converter edge.
// - Normal 13 cycles, first 25 cycles.
// - Sample at 1.5, first at 13.5.
// - Completion stores result unless locked, flags, clears start unless free running.
// - Auto: sample at 2, 13.5 total, sync.
// - Free run restarts at next rising edge, 14 cycles.
// - Selections copied until start, resume last cycle.
// - Processor halt starts an idle single conversion.
module sac_conv_ctrl #(
	parameter int TRIG_N = 7
) (
	input  wire logic              CLOCK_IN,          // System clock, 125 MHz.
	input  wire logic              RST_N_IN,          // Synchronous reset, active low.
	input  wire logic [2:0]        ADDR_IN,           // Register index.
	input  wire logic [7:0]        WR_DATA_IN,        // Write data.
	input  wire logic              WR_IN,             // Write strobe.
	input  wire logic              RD_IN,             // Read strobe.
	output logic      [7:0]        RD_DATA_OUT,       // Read data, cycle after strobe.
	input  wire logic [TRIG_N-1:0] TRIG_EVT_IN,       // Interrupt source events, pulses.
	input  wire logic              SLEEP_HALT_IN,     // Processor halted in quiet sleep.
	input  wire logic              CONV_POWER_OFF_IN, // Power reduction holds block off.
	input  wire logic [9:0]        RESULT_IN,         // Core result at completion.
	output sac_pkg::sac_core_type  CORE_OUT,          // Controls towards the core.
	output logic                   CONV_DONE_OUT      // Conversion complete flag.
);
	generate
		if (TRIG_N < 1 || TRIG_N > 7) begin : g_chk
			$error("TRIG_N must lie between 1 and 7.");
		end
	endgenerate

	sac_pkg::sac_state_type st_ff, nxt_st;
	logic [7:0]        selbuf_ff;
	logic [3:0]        ch_ff;
	logic              ref_ff;
	logic              en_ff, ate_ff, ladj_ff, done_ff;
	logic [2:0]        ps_ff, ts_ff;
	logic [TRIG_N-1:0] tflag_ff;
	logic              first_ff, auto_ff, lock_ff;
	logic [5:0]        hc_ff;
	logic [7:0]        pcnt_ff;
	logic [9:0]        res_ff;
	logic              trig_prev_ff, halt_prev_ff, samp_ff;
	logic [sac_pkg::TRIG_SYNC-1:0] tpipe_ff;
	logic [7:0]        rd_ff;
	logic              core_busy_ff;
	logic [1:0]        samp_cnt_ff;

	// Register decode.
	wire wr_sel  = WR_IN && (ADDR_IN == sac_pkg::OFF_SEL);
	wire wr_csa  = WR_IN && (ADDR_IN == sac_pkg::OFF_CSA);
	wire wr_csb  = WR_IN && (ADDR_IN == sac_pkg::OFF_CSB);
	wire wr_tflg = WR_IN && (ADDR_IN == sac_pkg::OFF_TFLG);
	wire rd_low  = RD_IN && (ADDR_IN == sac_pkg::OFF_RESL);
	wire rd_high = RD_IN && (ADDR_IN == sac_pkg::OFF_RESH);

	// Power reduction overrides the enable bit so a gated block stays quiet.
	wire run  = en_ff && !CONV_POWER_OFF_IN;
	wire busy = (st_ff == sac_pkg::ST_CONV);
	wire pend = (st_ff == sac_pkg::ST_WAIT);
	wire start_view = busy || pend;

	// Prescaler ticks: rising and falling edges of the converter clock.
	wire [8:0] div     = 9'h002 << ps_ff;
	wire [7:0] div_m1  = div[7:0] - 8'h01;
	wire [7:0] half_m1 = div[8:1] - 8'h01;
	wire rise_tick = run && (pcnt_ff == div_m1);
	wire fall_tick = run && (pcnt_ff == half_m1);
	wire htick     = rise_tick || fall_tick;

	// Trigger source choice; source zero is the completion flag.
	wire [2:0] tidx     = ts_ff - 3'h1;
	wire trig_sig       = (ts_ff == 3'h0) ? done_ff
		: ((int'(ts_ff) <= TRIG_N) ? tflag_ff[tidx] : 1'b0);
	wire free_run       = ate_ff && (ts_ff == 3'h0);
	// Edges that arrive while busy or pending are dropped here; a held level
	// never makes a new edge, so no retrigger at completion.
	// Free running restarts through the pending state instead, so the done
	// flag source must not also reset the prescaler behind its back.
	wire trig_edge      = run && ate_ff && !free_run && trig_sig && !trig_prev_ff
		&& !start_view;
	wire trig_go        = tpipe_ff[sac_pkg::TRIG_SYNC-1] && !busy && run;
	// Free running waits for the next rising edge, giving 14 cycles.
	wire sw_go          = pend && rise_tick;

	// Conversion length and sample point by kind.
	wire [5:0] hc_end  = first_ff ? sac_pkg::HC_FIRST_END
		: (auto_ff ? sac_pkg::HC_AUTO_END : sac_pkg::HC_NORM_END);
	wire [5:0] hc_samp = first_ff ? sac_pkg::HC_FIRST_SAMP
		: (auto_ff ? sac_pkg::HC_AUTO_SAMP : sac_pkg::HC_NORM_SAMP);
	wire complete = busy && htick && (hc_ff == hc_end - 6'h01);
	wire sample   = busy && htick && (hc_ff == hc_samp - 6'h01);
	// Selections follow the buffer until start and again in the last cycle.
	wire sel_copy = run && (!busy || (hc_ff >= hc_end - 6'h02));
	wire halt_go  = SLEEP_HALT_IN && !halt_prev_ff;
	wire sw_start = wr_csa && WR_DATA_IN[sac_pkg::CSA_START];

	// Sequencer next state.
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			sac_pkg::ST_IDLE: begin
				if (trig_go)
					nxt_st = sac_pkg::ST_CONV;
				else if (sw_start || (halt_go && !ate_ff))
					nxt_st = sac_pkg::ST_WAIT;
			end
			sac_pkg::ST_WAIT: begin
				if (sw_go)
					nxt_st = sac_pkg::ST_CONV;
			end
			sac_pkg::ST_CONV: begin
				if (complete)
					nxt_st = free_run ? sac_pkg::ST_WAIT : sac_pkg::ST_IDLE;
			end
			default: nxt_st = sac_pkg::ST_IDLE;
		endcase
		if (!run)
			nxt_st = sac_pkg::ST_IDLE;
	end

	// The busy output gets its own flop so the core sees no decode glitches.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			st_ff        <= sac_pkg::ST_IDLE;
			core_busy_ff <= 1'b0;
		end else begin
			st_ff        <= nxt_st;
			core_busy_ff <= (nxt_st == sac_pkg::ST_CONV);
		end
	end

	// Prescaler is held at zero while off and restarted by a trigger.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || !run || trig_go)
			pcnt_ff <= sac_pkg::RST_PCNT;
		else if (rise_tick)
			pcnt_ff <= sac_pkg::RST_PCNT;
		else
			pcnt_ff <= pcnt_ff + 8'h01;
	end

	// Half cycle counter and conversion kind, fixed at the start edge.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			hc_ff   <= sac_pkg::RST_HC;
			auto_ff <= 1'b0;
		end else if (trig_go || sw_go) begin
			hc_ff   <= sac_pkg::RST_HC;
			auto_ff <= trig_go;
		end else if (busy && htick) begin
			hc_ff   <= hc_ff + 6'h01;
		end
	end

	// The first conversion after enabling is long; it is re-armed by disable.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || !run)
			first_ff <= 1'b1;
		else if (complete)
			first_ff <= 1'b0;
	end

	// Sample pulses in the running conversion, kept only for the checks below.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || trig_go || sw_go)
			samp_cnt_ff <= 2'h0;
		else if (sample && samp_cnt_ff != 2'h3)
			samp_cnt_ff <= samp_cnt_ff + 2'h1;
	end

	// Software registers.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			selbuf_ff <= sac_pkg::RST_BYTE;
			en_ff     <= 1'b0;
			ate_ff    <= 1'b0;
			ps_ff     <= 3'h0;
			ladj_ff   <= 1'b0;
			ts_ff     <= 3'h0;
		end else begin
			if (wr_sel)
				selbuf_ff <= WR_DATA_IN;
			if (wr_csa) begin
				en_ff  <= WR_DATA_IN[sac_pkg::CSA_EN];
				ate_ff <= WR_DATA_IN[sac_pkg::CSA_ATE];
				ps_ff  <= WR_DATA_IN[2:0];
			end
			if (wr_csb) begin
				ladj_ff <= WR_DATA_IN[sac_pkg::CSB_LADJ];
				ts_ff   <= WR_DATA_IN[2:0];
			end
		end
	end

	// Active selections: untouched while disabled, locked during conversion until its last cycle.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			ch_ff  <= 4'h0;
			ref_ff <= 1'b0;
		end else if (sel_copy) begin
			ch_ff  <= selbuf_ff[3:0];
			ref_ff <= selbuf_ff[sac_pkg::SEL_REF];
		end
	end

	// Flags cleared by writing one; a same-cycle event wins over the clear.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			done_ff  <= 1'b0;
			tflag_ff <= '0;
		end else begin
			done_ff  <= complete || (done_ff && !(wr_csa && WR_DATA_IN[sac_pkg::CSA_DONE]));
			tflag_ff <= TRIG_EVT_IN
				| (tflag_ff & ~(wr_tflg ? WR_DATA_IN[TRIG_N-1:0] : '0));
		end
	end

	// Result interlock between the low and the high byte reads.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			lock_ff <= 1'b0;
			res_ff  <= sac_pkg::RST_RES;
		end else begin
			if (rd_low)
				lock_ff <= 1'b1;
			else if (rd_high)
				lock_ff <= 1'b0;
			if (complete && !lock_ff)
				res_ff <= RESULT_IN;
		end
	end

	// Trigger edge detect and a three clock synchroniser delay.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			trig_prev_ff <= 1'b0;
			halt_prev_ff <= 1'b0;
			tpipe_ff     <= '0;
			samp_ff      <= 1'b0;
		end else begin
			trig_prev_ff <= trig_sig;
			halt_prev_ff <= SLEEP_HALT_IN;
			tpipe_ff     <= {tpipe_ff[sac_pkg::TRIG_SYNC-2:0], trig_edge};
			samp_ff      <= sample;
		end
	end

	// Result bytes in either adjustment.
	wire [7:0] res_high = ladj_ff ? res_ff[9:2] : {6'h00, res_ff[9:8]};
	wire [7:0] res_low  = ladj_ff ? {res_ff[1:0], 6'h00} : res_ff[7:0];
	wire [7:0] csa_view = {en_ff, start_view, ate_ff, done_ff, 1'b0, ps_ff};
	wire [7:0] csb_view = {4'h0, ladj_ff, ts_ff};
	wire [7:0] tflg_view = 8'(tflag_ff);
	wire [7:0] rd_mux =
		(ADDR_IN == sac_pkg::OFF_SEL)  ? selbuf_ff :
		(ADDR_IN == sac_pkg::OFF_CSA)  ? csa_view :
		(ADDR_IN == sac_pkg::OFF_CSB)  ? csb_view :
		(ADDR_IN == sac_pkg::OFF_RESL) ? res_low :
		(ADDR_IN == sac_pkg::OFF_RESH) ? res_high :
		(ADDR_IN == sac_pkg::OFF_TFLG) ? tflg_view : 8'h00;

	// Read data holds only in the cycle after the strobe.
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || !RD_IN)
			rd_ff <= 8'h00;
		else
			rd_ff <= rd_mux;
	end

	assign RD_DATA_OUT      = rd_ff;
	assign CONV_DONE_OUT    = done_ff;
	// One driver for the whole carrier; every field comes from a flop.
	assign CORE_OUT = '{
		sample:  samp_ff,
		busy:    core_busy_ff,
		ref_sel: ref_ff,
		channel: ch_ff
	};

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);

	// A locked result survives a completion.
	a_lock_keeps_result: assert property (lock_ff && complete |=> $stable(res_ff))
		else $error("Result changed while interlocked.");
	// The flag is raised even when the result is dropped.
	a_flag_on_drop: assert property (lock_ff && complete |=> done_ff)
		else $error("Completion flag missing after dropped result.");
	// The start bit reads one through a whole conversion.
	a_start_reads_one: assert property (busy |-> csa_view[sac_pkg::CSA_START])
		else $error("Start bit low during conversion.");
	// The prescaler stays at zero while disabled.
	a_presc_held: assert property (!run ##1 !run |-> pcnt_ff == 8'h00)
		else $error("Prescaler counted while disabled.");
	// The channel does not move in the first converter cycle of a conversion.
	a_sel_locked: assert property (busy && hc_ff < 6'h02 |=> $stable(ch_ff))
		else $error("Channel changed during conversion.");
	// A single conversion ends with the start bit clear.
	a_single_ends: assert property (complete && !free_run |=> !start_view)
		else $error("Start bit not cleared after single conversion.");
	// Free running keeps the start bit high and restarts.
	a_free_restart: assert property (complete && free_run |=> pend ##[1:256] busy)
		else $error("Free running did not restart.");
	// A software start reaches the converter within one converter period.
	a_sw_start_edge: assert property ($rose(pend) |-> ##[1:256] (busy || !run))
		else $error("Software start did not begin on a converter edge.");
	// A trigger starts after three clocks with the prescaler reset.
	a_trig_starts: assert property (trig_edge ##1 run [*3] |=> busy && pcnt_ff == 8'h00)
		else $error("Trigger did not start a conversion.");
	// Disabled means the selections stay put.
	a_disabled_sel: assert property (!run |=> $stable(ch_ff) && $stable(ref_ff))
		else $error("Selection applied while disabled.");

	// Completion always raises the flag.
	a_done_on_complete: assert property (complete |=> done_ff)
		else $error("Completion flag not set.");
	// An unlocked completion stores the core result.
	a_result_stored: assert property (complete && !lock_ff |=> res_ff == $past(RESULT_IN))
		else $error("Result not stored at completion.");
	// Writing one clears the done flag when no completion competes.
	a_done_clear: assert property (wr_csa && WR_DATA_IN[sac_pkg::CSA_DONE] && !complete
		|=> !done_ff)
		else $error("Done flag not cleared by write.");
	// Source event zero sets its flag whatever the clear does.
	a_tflag_sets: assert property (TRIG_EVT_IN[0] |=> tflag_ff[0])
		else $error("Trigger flag not set by event.");
	// A low byte read locks the result pair.
	a_lock_on_low: assert property (rd_low |=> lock_ff)
		else $error("Low read did not lock.");
	// A high byte read releases the result pair.
	a_unlock_high: assert property (rd_high |=> !lock_ff)
		else $error("High read did not unlock.");

	// A software start from idle goes pending.
	a_start_pends: assert property (sw_start && run && st_ff == sac_pkg::ST_IDLE && !trig_go
		|=> pend)
		else $error("Software start not taken.");
	// A fresh halt starts an idle single conversion.
	a_halt_start: assert property (halt_go && run && !ate_ff && !trig_go
		&& st_ff == sac_pkg::ST_IDLE |=> pend)
		else $error("Halt did not start a conversion.");
	// A trigger start restarts the prescaler.
	a_presc_restart: assert property (trig_go |=> pcnt_ff == 8'h00)
		else $error("Prescaler not reset by trigger.");
	// Disabling stops any conversion at once.
	a_no_conv_off: assert property (!run |=> !busy)
		else $error("Conversion running while disabled.");

	// Exactly one sample and hold lands in every conversion.
	a_one_sample: assert property (complete |-> samp_cnt_ff == 2'h1)
		else $error("Sample count wrong at completion.");
	// The first conversion runs its full length.
	a_first_length: assert property (complete && first_ff
		|-> hc_ff == sac_pkg::HC_FIRST_END - 6'h01)
		else $error("First conversion length wrong.");
	// A normal conversion runs its normal length.
	a_norm_length: assert property (complete && !first_ff && !auto_ff
		|-> hc_ff == sac_pkg::HC_NORM_END - 6'h01)
		else $error("Normal conversion length wrong.");
	// An auto triggered conversion samples at its own point.
	a_auto_sample: assert property (sample && auto_ff && !first_ff
		|-> hc_ff == sac_pkg::HC_AUTO_SAMP - 6'h01)
		else $error("Auto sample point wrong.");
	// Between conversions the channel follows the buffer.
	a_sel_follows: assert property (run && !busy
		|=> {4'h0, ch_ff} == ($past(selbuf_ff) & 8'h0F))
		else $error("Channel did not follow the buffer.");
endmodule
`default_nettype wire

// File: sac_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the analog multiplexer and converter core.
module sac_core_model (
	input  wire logic                  clk_in,    // System clock.
	input  wire sac_pkg::sac_core_type core_in,   // Controls from the block.
	output logic      [9:0]            result_out // Code handed back.
);
	logic [9:0] held_ff;
	// The code is built from the selection seen at the sample pulse, so a
	// selection that changes too early shows up as a wrong result.
	always_ff @(posedge clk_in) begin
		if (core_in.sample) begin
			held_ff <= {core_in.ref_sel, core_in.channel, 5'h15};
		end
	end
	// Outside a conversion the core holds nothing valid, so show the inverse.
	assign result_out = core_in.busy ? held_ff : ~held_ff;
endmodule
`default_nettype wire

// File: sac_conv_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module sac_conv_ctrl_test;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [2:0]            addr = 3'h0;
	logic [7:0]            wdata = 8'h00;
	logic                  wr = 1'b0;
	logic                  rd = 1'b0;
	logic [6:0]            trig = 7'h00;
	logic                  halt = 1'b0;
	logic                  poff = 1'b0;
	logic [7:0]            rdata;
	logic [9:0]            result;
	logic                  done;
	sac_pkg::sac_core_type core;
	int                    mismatches = 0;
	int                    checks_done = 0;
	logic [7:0]            v;
	int                    a;
	int                    s;

	sac_conv_ctrl dut (
		.CLOCK_IN          (clk),
		.RST_N_IN          (rst_n),
		.ADDR_IN           (addr),
		.WR_DATA_IN        (wdata),
		.WR_IN             (wr),
		.RD_IN             (rd),
		.RD_DATA_OUT       (rdata),
		.TRIG_EVT_IN       (trig),
		.SLEEP_HALT_IN     (halt),
		.CONV_POWER_OFF_IN (poff),
		.RESULT_IN         (result),
		.CORE_OUT          (core),
		.CONV_DONE_OUT     (done)
	);
	sac_core_model core_model (
		.clk_in     (clk),
		.core_in    (core),
		.result_out (result)
	);

	// Free-running system clock, 8 ns period.
	initial begin
		forever #4 clk = ~clk;
	end

	// Value and count comparisons.
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cnt(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bus cycles; each ends one idle cycle later so strobes never reassign in a step.
	task automatic wr_reg(input logic [2:0] ad, input logic [7:0] d);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [2:0] ad, output logic [7:0] d);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic pulse(input int k);
		trig <= 7'(1 << k);
		@(posedge clk);
		trig <= 7'h00;
		@(posedge clk);
	endtask

	// Waits for a conversion under a bound, then counts busy and sample cycles.
	task automatic run_len(output int len, output int smp);
		int w;
		w = 0;
		len = 0;
		smp = 0;
		while (core.busy !== 1'b1 && w < 400) begin
			@(posedge clk);
			w++;
		end
		while (core.busy === 1'b1 && len < 400) begin
			smp += int'(core.sample);
			@(posedge clk);
			len++;
		end
	endtask

	// Single closing point for the normal end and the watchdog.
	task automatic conclude();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// The whole sequence takes under a thousand cycles; this bound is generous.
	initial begin
		#200000;
		mismatches++;
		conclude();
	end

	// Main sequence, divide-by-two prescaler so a converter cycle is two clocks.
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_reg(3'h6, v);
		chk(v, 8'h00);
		wr_reg(sac_pkg::OFF_SEL, 8'h45);
		repeat (4) @(posedge clk);
		chk({core.ref_sel, core.channel}, 5'h00);
		wr_reg(sac_pkg::OFF_CSA, 8'h80);
		repeat (4) @(posedge clk);
		chk({core.ref_sel, core.channel}, 5'h15);
		wr_reg(sac_pkg::OFF_CSA, 8'hC0);
		fork
			run_len(a, s);
			begin
				repeat (10) @(posedge clk);
				rd_reg(sac_pkg::OFF_CSA, v);
				chk(v, 8'hC0);
			end
		join
		cnt(a, 50);
		cnt(s, 1);
		rd_reg(sac_pkg::OFF_CSA, v);
		chk(v, 8'h90);
		rd_reg(sac_pkg::OFF_RESL, v);
		chk(v, 8'hB5);
		rd_reg(sac_pkg::OFF_RESH, v);
		chk(v, 8'h02);
		// A low read locks the pair; the next result is lost but still flagged.
		rd_reg(sac_pkg::OFF_RESL, v);
		wr_reg(sac_pkg::OFF_SEL, 8'h03);
		wr_reg(sac_pkg::OFF_CSA, 8'h90);
		chk(done, 1'b0);
		wr_reg(sac_pkg::OFF_CSA, 8'hC0);
		run_len(a, s);
		cnt(a, 26);
		@(posedge clk);
		chk(done, 1'b1);
		rd_reg(sac_pkg::OFF_RESH, v);
		chk(v, 8'h02);
		rd_reg(sac_pkg::OFF_RESL, v);
		chk(v, 8'hB5);
		rd_reg(sac_pkg::OFF_RESH, v);
		// Left adjusted, with a selection change in mid conversion.
		wr_reg(sac_pkg::OFF_CSB, 8'h08);
		wr_reg(sac_pkg::OFF_CSA, 8'hC0);
		fork
			run_len(a, s);
			begin
				repeat (8) @(posedge clk);
				wr_reg(sac_pkg::OFF_SEL, 8'h4A);
				chk(core.channel, 4'h3);
			end
		join
		rd_reg(sac_pkg::OFF_RESL, v);
		chk(v, 8'h40);
		rd_reg(sac_pkg::OFF_RESH, v);
		chk(v, 8'h1D);
		chk(core.channel, 4'hA);
		// Auto trigger on trigger flag 0.
		wr_reg(sac_pkg::OFF_CSB, 8'h01);
		wr_reg(sac_pkg::OFF_CSA, 8'hA0);
		fork
			run_len(a, s);
			begin
				pulse(0);
				repeat (8) @(posedge clk);
				pulse(0);
			end
		join
		cnt(s, 1);
		cnt(a, 27);
		rd_reg(sac_pkg::OFF_TFLG, v);
		chk(v, 8'h01);
		pulse(0);
		run_len(a, s);
		cnt(a, 0);
		wr_reg(sac_pkg::OFF_TFLG, 8'h01);
		pulse(0);
		run_len(a, s);
		cnt(s, 1);
		// Free running on the done flag, started by software.
		wr_reg(sac_pkg::OFF_CSA, 8'h80);
		wr_reg(sac_pkg::OFF_CSB, 8'h00);
		wr_reg(sac_pkg::OFF_CSA, 8'hE0);
		run_len(a, s);
		run_len(a, s);
		cnt(s, 1);
		rd_reg(sac_pkg::OFF_CSA, v);
		chk(v[6], 1'b1);
		wr_reg(sac_pkg::OFF_CSA, 8'h00);
		// The disable lands one clock before busy can fall.
		@(posedge clk);
		chk(core.busy, 1'b0);
		// Halt in sleep starts an idle single conversion.
		wr_reg(sac_pkg::OFF_CSA, 8'h80);
		halt <= 1'b1;
		run_len(a, s);
		cnt(a, 50);
		halt <= 1'b0;
		// Power reduction keeps a software start from running.
		poff <= 1'b1;
		wr_reg(sac_pkg::OFF_CSA, 8'hC0);
		repeat (4) @(posedge clk);
		chk(core.busy, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
